// ### core/ahs_pkg.sv
package ahs_pkg;
   // Clock and time base
   localparam int unsigned CLK_HZ = 25_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
   localparam int unsigned VCAM_DEF_MS = 5000;
   localparam logic [15:0] VCAM_DEF = 16'(VCAM_DEF_MS);

   // Register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_VHIGH = 8'h04;
   localparam logic [7:0] A_VMID = 8'h08;
   localparam logic [7:0] A_VLOW = 8'h0C;
   localparam logic [7:0] A_ZOFS = 8'h10;
   localparam logic [7:0] A_VCAM = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_POS = 8'h1C;

   // Control field positions
   localparam int C_GO = 0;
   localparam int C_POL = 1;
   localparam int C_ZS = 2;
   localparam int C_CAMF = 3;
   localparam int C_MT = 4;
   localparam int C_TY = 8;
   localparam int TY_W = 4;

   localparam logic [3:0] TY_ZERO = 4'h0;
   localparam logic [3:0] TY_MAX = 4'h8;
   localparam logic [30:0] SPEED_RST = 31'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_SEEK = 3'b001,
      S_EXIT = 3'b010,
      S_INDEX = 3'b011
   } ahs_state_t;
endpackage : ahs_pkg

// ### core/ahs_sync.sv
`timescale 1ns/1ps
module ahs_sync #(
   parameter int W = 1
) (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Sync reset
   input wire logic [W-1:0] d_i, // Asynchronous inputs
   output logic [W-1:0] q_o // Synchronised inputs
);
   logic [W-1:0] meta_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta_ff <= '0;
         q_o <= '0;
      end else begin
         meta_ff <= d_i;
         q_o <= meta_ff;
      end
   end
endmodule : ahs_sync

// ### core/ahs_vcam.sv
`timescale 1ns/1ps
module ahs_vcam (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Sync reset
   input wire logic start_i, // Homing start pulse
   input wire logic stop_i, // Run ended
   input wire logic ms_tick_i, // One-cycle millisecond enable
   input wire logic [15:0] time_ms_i, // Simulated cam time, 0 = default
   output logic cam_o // Virtual cam level
);
   import ahs_pkg::*;
   logic run_ff;
   logic [16:0] cnt_ff;
   logic [16:0] t_one;

   assign t_one = {1'b0, (time_ms_i == 16'h0000) ? VCAM_DEF : time_ms_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_ff <= 1'b0;
         cnt_ff <= 17'h00000;
         cam_o <= 1'b0;
      end else if (start_i) begin
         run_ff <= 1'b1;
         cnt_ff <= 17'h00000;
         cam_o <= 1'b0;
      end else if (stop_i) begin
         run_ff <= 1'b0;
         cam_o <= 1'b0;
      end else if (run_ff && ms_tick_i) begin
         cnt_ff <= cnt_ff + 17'h00001;
         // Rises after one period, falls after a second one
         if (cnt_ff + 17'h00001 == t_one) begin
            cam_o <= 1'b1;
         end
         if (cnt_ff + 17'h00001 == {t_one[15:0], 1'b0}) begin
            cam_o <= 1'b0;
            run_ff <= 1'b0;
         end
      end
   end
endmodule : ahs_vcam

// ### core/ahs_homing.sv
`timescale 1ns/1ps
module ahs_homing #(
   parameter int unsigned MS_DIV = ahs_pkg::MS_CYCLES
) (
   input wire logic clk_i, // 25 MHz clock
   input wire logic rst_i, // Sync reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [3:0] wb_sel_i, // Byte enables
   input wire logic [31:0] wb_dat_i, // Write data
   output logic [31:0] wb_dat_o, // Read data
   output logic wb_ack_o, // Acknowledge
   input wire logic go_i, // Go pin, rising edge starts homing
   input wire logic cam_input_pin_i, // Reference cam pin
   input wire logic lim_pos_i, // Positive hardware limit
   input wire logic lim_neg_i, // Negative hardware limit
   input wire logic index_pulse_i, // Encoder index pulse
   input wire logic enc_inc_i, // Encoder count up
   input wire logic enc_dec_i, // Encoder count down
   input wire logic [31:0] mt_pos_i, // Multi-turn encoder position
   output logic move_en_o, // Axis motion request
   output logic move_cw_o, // 1 = positive = clockwise
   output logic [30:0] speed_o, // Commanded reference speed
   output logic homing_done_o, // Homing complete
   output logic ref_defined_o, // Reference point defined
   output logic sw_limit_mon_o // Software limit monitoring enabled
);
   import ahs_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Inputs and time base
   logic [6:0] pin_s;
   logic go_s, cam_s, lp_s, ln_s, idx_s, inc_s, dec_s;
   logic go_q, idx_q;
   logic [14:0] ms_cnt_ff;
   logic ms_tick_ff;

   ahs_sync #(.W(7)) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({go_i, cam_input_pin_i, lim_pos_i, lim_neg_i, index_pulse_i, enc_inc_i, enc_dec_i}),
      .q_o(pin_s)
   );
   assign {go_s, cam_s, lp_s, ln_s, idx_s, inc_s, dec_s} = pin_s;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_q <= 1'b0;
         idx_q <= 1'b0;
      end else begin
         go_q <= go_s;
         idx_q <= idx_s;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || ms_cnt_ff == 15'(MS_DIV - 1)) begin
         ms_cnt_ff <= 15'h0000;
      end else begin
         ms_cnt_ff <= ms_cnt_ff + 15'h0001;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ms_tick_ff <= 1'b0;
      end else begin
         ms_tick_ff <= (ms_cnt_ff == 15'(MS_DIV - 1));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic pol_ff, zs_ff, camf_ff, mt_ff;
   logic [3:0] ty_ff;
   logic [30:0] v_high_ff, v_mid_ff, v_low_ff;
   logic [31:0] zofs_ff, pos_ff;
   logic [15:0] vcam_t_ff;
   logic wr, sw_go, sw_go_ff;
   logic [31:0] ctrl_rd, stat_rd, rd_mux, ctrl_wr;
   ahs_state_t state_ff;
   logic dir_ff, move_ff;

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction : be_merge

   // Write lands on the edge where the master sees ack
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_ff;
   assign sw_go = wr && wb_adr_i == A_CTRL && wb_sel_i[0] && wb_dat_i[C_GO];
   assign ctrl_rd = {20'h00000, ty_ff, 3'h0, mt_ff, camf_ff, zs_ff, pol_ff, 1'b0};
   assign ctrl_wr = be_merge(ctrl_rd, wb_dat_i, wb_sel_i);
   assign stat_rd = {24'h000000, state_ff, dir_ff, move_ff, sw_limit_mon_o, ref_defined_o, homing_done_o};

   always_comb begin
      case (wb_adr_i)
         A_CTRL: rd_mux = ctrl_rd;
         A_VHIGH: rd_mux = {1'b0, v_high_ff};
         A_VMID: rd_mux = {1'b0, v_mid_ff};
         A_VLOW: rd_mux = {1'b0, v_low_ff};
         A_ZOFS: rd_mux = zofs_ff;
         A_VCAM: rd_mux = {16'h0000, vcam_t_ff};
         A_STAT: rd_mux = stat_rd;
         A_POS: rd_mux = pos_ff;
         default: rd_mux = WORD_ZERO;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdat_ff <= WORD_ZERO;
         sw_go_ff <= 1'b0;
      end else begin
         ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
         rdat_ff <= rd_mux;
         sw_go_ff <= sw_go; // Go acts a cycle late, so the type written with it is used
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {ty_ff, mt_ff, camf_ff, zs_ff, pol_ff} <= 8'h00;
         v_high_ff <= SPEED_RST;
         v_mid_ff <= SPEED_RST;
         v_low_ff <= SPEED_RST;
         zofs_ff <= WORD_ZERO;
         vcam_t_ff <= 16'h0000;
      end else if (wr) begin
         case (wb_adr_i)
            A_CTRL: begin
               {pol_ff, zs_ff, camf_ff, mt_ff} <= {ctrl_wr[C_POL], ctrl_wr[C_ZS], ctrl_wr[C_CAMF], ctrl_wr[C_MT]};
               ty_ff <= ctrl_wr[C_TY +: TY_W];
            end
            A_VHIGH: v_high_ff <= 31'(be_merge({1'b0, v_high_ff}, wb_dat_i, wb_sel_i));
            A_VMID: v_mid_ff <= 31'(be_merge({1'b0, v_mid_ff}, wb_dat_i, wb_sel_i));
            A_VLOW: v_low_ff <= 31'(be_merge({1'b0, v_low_ff}, wb_dat_i, wb_sel_i));
            A_ZOFS: zofs_ff <= be_merge(zofs_ff, wb_dat_i, wb_sel_i);
            A_VCAM: vcam_t_ff <= 16'(be_merge({16'h0000, vcam_t_ff}, wb_dat_i, wb_sel_i));
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Homing sequencer
   logic start, cam_act, vcam, lim_hit, idx_rise, fin, ty0, exit_ty;
   logic seek_pos, exit_pos;
   ahs_state_t nxt_state;
   logic nxt_dir;

   assign start = (sw_go_ff || (go_s && !go_q)) && state_ff == S_IDLE && ty_ff <= TY_MAX;
   assign ty0 = start && ty_ff == TY_ZERO;
   assign idx_rise = idx_s && !idx_q;
   // Reach types 3..6 search the cam, then the index if zero search is set; exit types leave the cam first
   assign exit_ty = ty_ff == 4'h1 || ty_ff == 4'h2 || ty_ff == 4'h7 || ty_ff == 4'h8;
   assign seek_pos = !(ty_ff == 4'h4 || ty_ff == 4'h5 || ty_ff == 4'h7);
   assign exit_pos = !(ty_ff == 4'h8);
   // Cam level: open contact active high, closed contact active low
   assign cam_act = camf_ff ? (pol_ff ? cam_s : !cam_s) : vcam;
   assign lim_hit = (dir_ff && lp_s) || (!dir_ff && ln_s);

   ahs_vcam u_vcam (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start && !ty0 && !camf_ff),
      .stop_i(fin),
      .ms_tick_i(ms_tick_ff),
      .time_ms_i(vcam_t_ff),
      .cam_o(vcam)
   );

   always_comb begin
      nxt_state = state_ff;
      nxt_dir = dir_ff;
      fin = 1'b0;
      // Limits only flip direction; the run carries on
      if (state_ff != S_IDLE && lim_hit) begin
         nxt_dir = !dir_ff;
      end
      case (state_ff)
         S_IDLE: begin
            if (start && !ty0) begin
               nxt_state = S_SEEK;
               nxt_dir = seek_pos;
            end
         end
         S_SEEK: begin
            if (cam_act) begin
               if (exit_ty) begin
                  nxt_state = S_EXIT;
                  nxt_dir = exit_pos;
               end else if (zs_ff) begin
                  nxt_state = S_INDEX;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         S_EXIT: begin
            if (!cam_act) begin
               if (zs_ff) begin
                  nxt_state = S_INDEX;
               end else begin
                  fin = 1'b1;
               end
            end
         end
         S_INDEX: begin
            if (idx_rise) begin
               fin = 1'b1;
            end
         end
         default: nxt_state = S_IDLE;
      endcase
      if (fin) begin
         nxt_state = S_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= S_IDLE;
         dir_ff <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         dir_ff <= nxt_dir;
      end
   end

   // Motion outputs; speed tracks the phase
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         move_ff <= 1'b0;
         speed_o <= SPEED_RST;
      end else begin
         move_ff <= nxt_state != S_IDLE;
         case (nxt_state)
            S_SEEK: speed_o <= v_high_ff;
            S_EXIT: speed_o <= v_mid_ff;
            S_INDEX: speed_o <= v_low_ff;
            default: speed_o <= SPEED_RST;
         endcase
      end
   end
   assign move_en_o = move_ff;
   assign move_cw_o = dir_ff;

   // Status flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         homing_done_o <= 1'b0;
         ref_defined_o <= 1'b0;
         sw_limit_mon_o <= 1'b1;
      end else begin
         if (fin || ty0) begin
            homing_done_o <= 1'b1;
            ref_defined_o <= 1'b1;
         end else if (start) begin
            homing_done_o <= 1'b0;
            ref_defined_o <= 1'b0;
         end
         sw_limit_mon_o <= nxt_state == S_IDLE;
      end
   end

   // Actual position; encoder counts between loads
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pos_ff <= WORD_ZERO;
      end else if (ty0) begin
         pos_ff <= mt_ff ? mt_pos_i + zofs_ff : zofs_ff;
      end else if (fin) begin
         pos_ff <= zofs_ff;
      end else if (inc_s && !dec_s) begin
         pos_ff <= pos_ff + 32'h00000001;
      end else if (dec_s && !inc_s) begin
         pos_ff <= pos_ff - 32'h00000001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   property p_swlim;
      @(posedge clk_i) disable iff (rst_i) (state_ff != S_IDLE) |-> !sw_limit_mon_o;
   endproperty
   a_swlim: assert property (p_swlim) else $error("soft limit watched while homing");

   property p_clear;
      @(posedge clk_i) disable iff (rst_i) (start && ty_ff != TY_ZERO) |=> !homing_done_o && !ref_defined_o
         ##0 (!homing_done_o throughout (state_ff != S_IDLE)[*1]);
   endproperty
   a_clear: assert property (p_clear) else $error("flags not cleared at start");

   property p_ty0;
      @(posedge clk_i) disable iff (rst_i) ty0 |=> ref_defined_o && homing_done_o && !move_en_o
         && pos_ff == (mt_ff ? $past(mt_pos_i) + zofs_ff : zofs_ff);
   endproperty
   a_ty0: assert property (p_ty0) else $error("type zero result wrong");

   property p_index;
      @(posedge clk_i) disable iff (rst_i) (state_ff == S_INDEX && idx_rise) |=> homing_done_o ##1 !move_en_o;
   endproperty
   a_index: assert property (p_index) else $error("done not set at index");

   property p_pos;
      @(posedge clk_i) disable iff (rst_i) (fin && !ty0) |=> pos_ff == $past(zofs_ff) && state_ff == S_IDLE;
   endproperty
   a_pos: assert property (p_pos) else $error("offset not loaded");

   property p_rev;
      @(posedge clk_i) disable iff (rst_i) (state_ff == S_SEEK && !cam_act && (dir_ff ? lp_s : ln_s))
         |=> dir_ff != $past(dir_ff);
   endproperty
   a_rev: assert property (p_rev) else $error("no reversal at limit");

   property p_speed;
      @(posedge clk_i) disable iff (rst_i) $rose(state_ff == S_INDEX) |-> speed_o == v_low_ff && move_en_o;
   endproperty
   a_speed: assert property (p_speed) else $error("index search not at low speed");

   property p_nozs;
      @(posedge clk_i) disable iff (rst_i) (state_ff == S_EXIT && !cam_act && !zs_ff) |=> homing_done_o
         && state_ff == S_IDLE;
   endproperty
   a_nozs: assert property (p_nozs) else $error("cam-only homing did not finish");
endmodule : ahs_homing

// ### dv/ahs_axis_model.sv
`timescale 1ns/1ps
module ahs_axis_model (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Sync reset
   input wire logic move_en_i, // Motion request
   input wire logic move_cw_i, // 1 = positive travel
   input wire logic cam_pol_i, // 1 = normally open cam
   output logic cam_o, // Cam contact level
   output logic lim_pos_o, // Positive hardware limit
   output logic lim_neg_o, // Negative hardware limit
   output logic index_o, // Index window
   output logic inc_o, // Count up pulse
   output logic dec_o // Count down pulse
);
   localparam int LIM = 160;
   localparam int IDX = 16;
   // Slow steps, so no count is still in flight when the run finishes
   localparam int STEP = 8;
   int pos = 0;
   int cam_lo = 40;
   int cam_hi = 80;
   int div = 0;
   logic on_cam;
   initial begin
      inc_o = 1'b0;
      dec_o = 1'b0;
   end
   always @(posedge clk_i) begin
      inc_o <= 1'b0;
      dec_o <= 1'b0;
      if (rst_i || !move_en_i) div <= 0;
      else if (div != STEP - 1) div <= div + 1;
      else begin
         div <= 0;
         if (move_cw_i && pos < LIM) begin
            pos <= pos + 1;
            inc_o <= 1'b1;
         end else if (!move_cw_i && pos > -LIM) begin
            pos <= pos - 1;
            dec_o <= 1'b1;
         end
      end
   end
   assign on_cam = pos >= cam_lo && pos <= cam_hi;
   assign cam_o = on_cam ~^ cam_pol_i;
   assign lim_pos_o = pos >= LIM;
   assign lim_neg_o = pos <= -LIM;
   assign index_o = (pos % IDX) == 0;
endmodule : ahs_axis_model

// ### dv/ahs_homing_tb_top.sv
`timescale 1ns/1ps
module ahs_homing_tb_top;
   import ahs_pkg::*;
   localparam int MSD = 10;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0;
   logic go = 1'b0;
   logic pol = 1'b1;
   logic [31:0] mt = 32'h0;
   logic [31:0] rdat;
   logic ack, cam, lp, ln, idx, inc, dec, men, mcw, done, refd, swm;
   logic [30:0] spd;
   logic [31:0] vh;
   logic idx_q = 1'b0;
   int idx_age = 0;
   int fails = 0;
   int comparisons = 0;

   initial forever #20 clk_i = ~clk_i;

   ahs_homing #(.MS_DIV(MSD)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .go_i(go), .cam_input_pin_i(cam), .lim_pos_i(lp), .lim_neg_i(ln), .index_pulse_i(idx),
      .enc_inc_i(inc), .enc_dec_i(dec), .mt_pos_i(mt), .move_en_o(men), .move_cw_o(mcw),
      .speed_o(spd), .homing_done_o(done), .ref_defined_o(refd), .sw_limit_mon_o(swm));

   ahs_axis_model p (.clk_i(clk_i), .rst_i(rst_i), .move_en_i(men), .move_cw_i(mcw), .cam_pol_i(pol),
      .cam_o(cam), .lim_pos_o(lp), .lim_neg_o(ln), .index_o(idx), .inc_o(inc), .dec_o(dec));

   always @(posedge clk_i) begin
      idx_q <= idx;
      idx_age <= (idx && !idx_q) ? 0 : idx_age + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize

   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
                     output logic [31:0] q);
      int k;
      k = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack !== 1'b1);
      chk("wb_ack_wait", 2, k);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   function automatic bit seek_cw(int t);
      return t inside {1, 2, 3, 6, 8};
   endfunction : seek_cw

   // Partner position where the run must stop; type 4 takes the limit detour
   function automatic int exp_stop(int t, bit zs);
      case (t)
         1, 2: return zs ? 96 : 81;
         3: return zs ? 48 : 40;
         5: return zs ? -128 : -120;
         6: return zs ? 128 : 120;
         7: return zs ? -112 : -119;
         default: return zs ? 112 : 119;
      endcase
   endfunction : exp_stop

   task automatic run(input int t, input bit zs, input bit camf, input bit mt_on, input bit pin, output int n);
      logic [31:0] ofs, q, e;
      bit pl, s0, s1, moved;
      int lo;
      ofs = $urandom;
      pl = 1'($urandom);
      s0 = 0;
      s1 = 0;
      moved = 0;
      lo = (t == 5 || t == 7) ? -160 : (t == 6 || t == 8) ? 120 : 40;
      pol <= pl;
      p.pos = 0;
      p.cam_lo = lo;
      p.cam_hi = lo + 40;
      wb(1'b1, A_ZOFS, 4'hF, ofs, q);
      wb(1'b1, A_CTRL, 4'hF, {20'h0, 4'(t), 3'b000, mt_on, camf, zs, pl, !pin}, q);
      if (pin) begin
         go <= 1'b1;
         repeat (4) @(posedge clk_i);
         go <= 1'b0;
      end
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
         if (n == 1 && t != 0 && !pin) begin
            chk("move_en", 1, men);
            chk("done_clr", 0, done);
            chk("ref_clr", 0, refd);
            chk("sw_lim_run", 0, swm);
            chk("speed", vh, {1'b0, spd});
            chk("dir", 32'(seek_cw(t)), mcw);
         end
         if (men === 1'b1) begin
            moved = 1;
            if (mcw === 1'b1) s1 = 1;
            else s0 = 1;
         end
      end while (done !== 1'b1 && n < 20000);
      repeat (4) @(posedge clk_i);
      #1;
      chk("done", 1, done);
      chk("ref_def", 1, refd);
      chk("move_end", 0, men);
      chk("sw_lim_end", 1, swm);
      e = (t == 0 && mt_on) ? mt + ofs : ofs;
      wb(1'b0, A_POS, 4'hF, 32'h0, q);
      chk("pos", e, q);
      if (t == 0) chk("moved", 0, moved);
      if (t == 4) chk("reversed", 1, s0 && s1);
      if (camf && t != 0 && t != 4) chk("stop_pos", exp_stop(t, zs), p.pos);
      if (camf && zs && t != 0) chk("index_age", 1, idx_age <= 16);
      $display("test type %0d search %0d virtual %0d ended", t, zs, !camf);
   endtask : run

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk_i);
      fails++;
      summarize();
   end

   initial begin
      logic [31:0] q;
      int n;
      void'($urandom(32'h6c1c41e8));
      vh = {1'b0, 31'($urandom)};
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("rst_swm", 1, swm);
      chk("rst_dir", 1, mcw);
      chk("rst_done", 0, done);
      wb(1'b1, A_VHIGH, 4'hF, vh, q);
      wb(1'b1, A_VMID, 4'hF, {1'b0, 31'($urandom)}, q);
      wb(1'b1, A_VLOW, 4'hF, {1'b0, 31'($urandom)}, q);
      wb(1'b0, A_VHIGH, 4'hF, 32'h0, q);
      chk("vhigh", vh, q);
      wb(1'b0, 8'h20, 4'hF, 32'h0, q);
      chk("unmapped", 0, q);
      wb(1'b1, A_ZOFS, 4'hF, 32'h0, q);
      wb(1'b1, A_ZOFS, 4'h2, 32'hFFFFFFFF, q);
      wb(1'b0, A_ZOFS, 4'hF, 32'h0, q);
      chk("byte_sel", 32'h0000FF00, q);
      $display("test registers ended");
      run(0, 0, 1, 0, 0, n);
      mt <= $urandom;
      run(0, 0, 1, 1, 1, n);
      for (int t = 1; t <= 8; t++) begin
         for (int z = 0; z < 2; z++) run(t, z[0], 1, 0, 0, n);
      end
      // Default 5000 ms cam time is left out: too long for this run
      wb(1'b1, A_VCAM, 4'hF, 32'h3, q);
      run(3, 0, 0, 0, 0, n);
      chk("vcam_time", 1, n >= 20 && n <= 36);
      wb(1'b1, A_CTRL, 4'hF, 32'h00000909, q);
      repeat (3) @(posedge clk_i);
      #1;
      chk("refused", 0, men);
      chk("keep_done", 1, done);
      $display("test refused start ended");
      summarize();
   end
endmodule : ahs_homing_tb_top
